// ### hw/csd_regs.vh
// register map, field positions, reset values and timing figures
// for the converter status and diagnostic register bank
// assumes a 100 MHz core clock and a 1K byte register window
`ifndef CSD_REGS_VH
`define CSD_REGS_VH

// window and data widths
`define CSD_AW               10
`define CSD_DW               16
`define CSD_NCH              8

// byte offsets inside the 1K window
`define CSD_ADDR_ACTIVE      10'h074
`define CSD_ADDR_TEST_EN     10'h07C
`define CSD_ADDR_SIG_STAT    10'h080
`define CSD_ADDR_REF_STAT    10'h084
`define CSD_ADDR_TEST_STAT   10'h088
`define CSD_ADDR_IRQ_EN      10'h098
`define CSD_ADDR_IRQ_STAT    10'h09C
`define CSD_ADDR_WDOG        10'h108
`define CSD_ADDR_SOFT_RST    10'h10C
`define CSD_ADDR_PART        10'h110
`define CSD_ADDR_SERIAL      10'h114
`define CSD_ADDR_DATE        10'h118
`define CSD_ADDR_REV_IFACE   10'h124
`define CSD_ADDR_REV_LOGIC   10'h128

// test enable fields
`define CSD_TEST_LOOPBACK    0
`define CSD_TEST_BACKGROUND  2
`define CSD_TEST_STIMULUS    3

// interrupt source bit positions, also status kind index
`define CSD_SRC_SIG          0
`define CSD_SRC_REF          1
`define CSD_SRC_TEST         2
`define CSD_NSRC             3

// soft reset control bit
`define CSD_SOFT_RST_BIT     0

// reset values
`define CSD_ZERO16           16'h0000
`define CSD_ZERO8            8'h00
`define CSD_PASS8            8'hFF
`define CSD_ZERO3            3'h0

// timing figures in their own units
`define CSD_CLK_HZ           100000000
`define CSD_CYC_PER_MS       (`CSD_CLK_HZ / 1000)
`define CSD_CYC_PER_US       (`CSD_CLK_HZ / 1000000)
`define CSD_SCAN_MS          250
`define CSD_LOSS_S           2
`define CSD_WDOG_US          100
`define CSD_BOOT_MS          400
`define CSD_TEST_S           36'd45

`endif

// ### hw/csd_status_regs.v
// host-visible status and diagnostic registers of an eight channel
// angle converter card: latched status, watchdog, soft reset, interrupts, ids
// assumes the memory window decode of the host bus hands over a 10-bit
// byte offset with one-cycle read and write strobes, all synchronous to clk_i
//
// How it works
// [R01] test status: one pass bit per active channel
// [R02] test failure latches; host read releases latch
// [R03] accuracy result published after each 45 s cycle
// [R04] reference bit 1 present, loss within 2 s; code flags loss only after 2 s low, at the next scan
// [R05] reference monitoring paused during stimulus/loopback tests
// [R06] reference failure latches; host read releases latch
// [R07] signal bit 1 valid, loss after 2 s
// [R08] signal monitoring paused during stimulus/loopback tests
// [R09] signal failure latches; host read releases latch
// [R10] changes held in background, loaded within 250 ms
// [R11] host waits 250 ms for refreshed status
// [R12] soft reset level held; release reboots 400 ms
// [R13] finished reboot clears registers like power-on
// [R14] watchdog code inverted within 100 us, then held
// [R15] host checks inverted watchdog after 100 us
// [R16] three interrupt sources individually enabled
// [R17] interrupt status latches source, clears on read
// [R18] part and serial numbers as 16-bit words
// [R19] date code as year-week decimal digits
// [R20] revision words equal actual revision
// [R21] registers live inside a 1K window
// [R22] sources: signal 1, reference 2, test 4
// [R23] host marks active channels, channel 1 bit 0
// [R24] irq asserted while enabled status bit set
`timescale 1ns/1ns
`include "csd_regs.vh"

module csd_status_regs #(
	parameter [31:0] SCAN_CYC   = `CSD_SCAN_MS * `CSD_CYC_PER_MS,
	parameter [31:0] LOSS_CYC   = `CSD_LOSS_S * `CSD_CLK_HZ,
	parameter [31:0] WDOG_CYC   = `CSD_WDOG_US * `CSD_CYC_PER_US,
	parameter [31:0] BOOT_CYC   = `CSD_BOOT_MS * `CSD_CYC_PER_MS,
	parameter [35:0] TEST_CYC   = `CSD_TEST_S * `CSD_CLK_HZ,
	parameter [15:0] PART_ID    = 16'h1234, // arbitrary value
	parameter [15:0] SERIAL_NO  = 16'h0001, // arbitrary value
	parameter [15:0] DATE_CODE  = 16'h2401, // arbitrary value, bcd year-week
	parameter [15:0] REV_IFACE  = 16'h0001, // arbitrary value
	parameter [15:0] REV_LOGIC  = 16'h0001  // arbitrary value
) (
	// clock and reset
	input  wire                   clk_i,
	input  wire                   resetn_i,
	// register window port
	input  wire [`CSD_AW-1:0]     reg_addr_i,
	input  wire                   reg_wr_i,
	input  wire                   reg_rd_i,
	input  wire [`CSD_DW-1:0]     reg_wdata_i,
	output reg  [`CSD_DW-1:0]     reg_rdata_o,
	output reg                    reg_rvalid_o,
	// raw per-channel monitors from the converter
	input  wire [`CSD_NCH-1:0]    sig_ok_i,
	input  wire [`CSD_NCH-1:0]    ref_ok_i,
	input  wire [`CSD_NCH-1:0]    test_fail_i,
	// controls to the converter and firmware
	output wire [`CSD_NCH-1:0]    active_channels_o,
	output wire                   internal_stimulus_test_o,
	output wire                   user_angle_loopback_test_o,
	output wire                   background_accuracy_test_o,
	output wire                   firmware_reset_o,
	// interrupt request to the host
	output wire                   irq_o
);

	// reset release through two flops
	reg rst_meta;
	reg rst_n;
	always @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// decoded strobes
	reg  [`CSD_NCH-1:0] active;
	reg  [`CSD_DW-1:0]  test_en;
	reg                 soft_clr;
	wire                wr_active = reg_wr_i && (reg_addr_i == `CSD_ADDR_ACTIVE);
	wire                wr_test   = reg_wr_i && (reg_addr_i == `CSD_ADDR_TEST_EN);
	wire                wr_irq_en = reg_wr_i && (reg_addr_i == `CSD_ADDR_IRQ_EN);
	wire                wr_wdog   = reg_wr_i && (reg_addr_i == `CSD_ADDR_WDOG);
	wire                wr_soft   = reg_wr_i && (reg_addr_i == `CSD_ADDR_SOFT_RST);
	wire                rd_irq    = reg_rd_i && (reg_addr_i == `CSD_ADDR_IRQ_STAT);
	wire [`CSD_NSRC-1:0] rd_stat;
	assign rd_stat[`CSD_SRC_SIG]  = reg_rd_i && (reg_addr_i == `CSD_ADDR_SIG_STAT);
	assign rd_stat[`CSD_SRC_REF]  = reg_rd_i && (reg_addr_i == `CSD_ADDR_REF_STAT);
	assign rd_stat[`CSD_SRC_TEST] = reg_rd_i && (reg_addr_i == `CSD_ADDR_TEST_STAT);

	// test modes that cut the channels off the outside world, and those that run the accuracy test
	wire suspend = test_en[`CSD_TEST_STIMULUS] | test_en[`CSD_TEST_LOOPBACK];
	wire acc_run = test_en[`CSD_TEST_STIMULUS] | test_en[`CSD_TEST_BACKGROUND];

	// host controls; soft_clr acts as a second, synchronous power-on
	always @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			active  <= `CSD_ZERO8;
			test_en <= `CSD_ZERO16;
		end
		else if (soft_clr) // [R13]
		begin
			active  <= `CSD_ZERO8;
			test_en <= `CSD_ZERO16;
		end
		else
		begin
			if (wr_active)
				active <= reg_wdata_i[`CSD_NCH-1:0]; // [R23]
			if (wr_test)
				test_en <= reg_wdata_i;
		end
	end

	// scan tick paces status refresh; one full channel scan per tick
	reg [31:0] scan_cnt;
	reg        scan_tick;
	always @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scan_cnt  <= 32'h00000000;
			scan_tick <= 1'b0;
		end
		else if (scan_cnt >= SCAN_CYC - 32'h00000001)
		begin
			scan_cnt  <= 32'h00000000;
			scan_tick <= 1'b1; // [R10]
		end
		else
		begin
			scan_cnt  <= scan_cnt + 32'h00000001;
			scan_tick <= 1'b0;
		end
	end

	// loss filters: a monitor must stay low for the full window to count
	wire [2*`CSD_NCH-1:0] raw_ok = {ref_ok_i, sig_ok_i};
	wire [2*`CSD_NCH-1:0] filt_ok;
	genvar gi;
	generate
		for (gi = 0; gi < 2*`CSD_NCH; gi = gi + 1)
		begin : g_loss
			reg [31:0] low_cnt;
			always @(posedge clk_i or negedge rst_n)
			begin
				if (!rst_n)
					low_cnt <= 32'h00000000;
				else if (raw_ok[gi] || soft_clr)
					low_cnt <= 32'h00000000;
				else if (low_cnt < LOSS_CYC)
					low_cnt <= low_cnt + 32'h00000001; // [R04] [R07]
			end
			assign filt_ok[gi] = (low_cnt < LOSS_CYC);
		end
	endgenerate

	// accuracy test cycle; result published only at cycle end
	reg [35:0]          test_cnt;
	reg [`CSD_NCH-1:0]  test_acc;
	reg [`CSD_NCH-1:0]  test_live;
	always @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			test_cnt  <= 36'h000000000;
			test_acc  <= `CSD_ZERO8;
			test_live <= `CSD_PASS8;
		end
		else if (soft_clr || !acc_run)
		begin
			test_cnt  <= 36'h000000000;
			test_acc  <= `CSD_ZERO8;
			test_live <= soft_clr ? `CSD_PASS8 : test_live; // [R13]
		end
		else if (test_cnt >= TEST_CYC - 36'h000000001)
		begin
			test_cnt  <= 36'h000000000;
			test_acc  <= `CSD_ZERO8;
			test_live <= ~(test_acc | test_fail_i); // [R03]
		end
		else
		begin
			test_cnt  <= test_cnt + 36'h000000001;
			test_acc  <= test_acc | test_fail_i;
		end
	end

	// latched status per kind: sig, ref, test
	wire [`CSD_NCH*`CSD_NSRC-1:0] live_all = {test_live, filt_ok};
	wire [`CSD_NCH*`CSD_NSRC-1:0] stat_all;
	wire [`CSD_NSRC-1:0]          stat_event;
	genvar gk;
	generate
		for (gk = 0; gk < `CSD_NSRC; gk = gk + 1)
		begin : g_stat
			reg  [`CSD_NCH-1:0] stat;
			reg  [`CSD_NCH-1:0] fail_acc;
			reg                 latched;
			reg                 event_p;
			// monitoring of reference and signal pauses in cut-off tests
			wire                mon_en   = (gk == `CSD_SRC_TEST) ? 1'b1 : ~suspend; // [R05] [R08]
			wire [`CSD_NCH-1:0] live     = live_all[gk*`CSD_NCH +: `CSD_NCH];
			wire [`CSD_NCH-1:0] fail_now = active & ~live & {`CSD_NCH{mon_en}};
			wire [`CSD_NCH-1:0] fail_all = fail_acc | fail_now;
			always @(posedge clk_i or negedge rst_n)
			begin
				if (!rst_n)
				begin
					stat     <= `CSD_ZERO8;
					fail_acc <= `CSD_ZERO8;
					latched  <= 1'b0;
					event_p  <= 1'b0;
				end
				else if (soft_clr)
				begin
					stat     <= `CSD_ZERO8;
					fail_acc <= `CSD_ZERO8;
					latched  <= 1'b0;
					event_p  <= 1'b0;
				end
				else if (scan_tick && mon_en && !latched)
				begin
					// transients since the last scan count as failures
					stat     <= active & live & ~fail_all; // [R01] [R04] [R07]
					fail_acc <= `CSD_ZERO8;
					latched  <= |fail_all; // [R02] [R06] [R09]
					event_p  <= |fail_all;
				end
				else
				begin
					// release on read; a failure in that cycle is kept
					fail_acc <= rd_stat[gk] ? fail_now : fail_all;
					event_p  <= 1'b0;
					if (rd_stat[gk])
						latched <= 1'b0; // [R02] [R06] [R09] [R10]
				end
			end
			assign stat_all[gk*`CSD_NCH +: `CSD_NCH] = stat;
			assign stat_event[gk] = event_p;
		end
	endgenerate

	// interrupt enable and latched source status
	reg [`CSD_NSRC-1:0] irq_en;
	reg [`CSD_NSRC-1:0] irq_stat;
	always @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_en   <= `CSD_ZERO3;
			irq_stat <= `CSD_ZERO3;
		end
		else if (soft_clr)
		begin
			irq_en   <= `CSD_ZERO3;
			irq_stat <= `CSD_ZERO3;
		end
		else
		begin
			if (wr_irq_en)
				irq_en <= reg_wdata_i[`CSD_NSRC-1:0]; // [R16] [R22]
			// set wins over the clear of a same-cycle read
			irq_stat <= (rd_irq ? `CSD_ZERO3 : irq_stat) | (stat_event & irq_en); // [R17] [R22]
		end
	end
	assign irq_o = |(irq_stat & irq_en); // [R24]

	// watchdog: the card answers a written code with its inverse
	reg [`CSD_DW-1:0] wdog;
	reg [31:0]        wdog_cnt;
	reg               wdog_pend;
	always @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wdog      <= `CSD_ZERO16;
			wdog_cnt  <= 32'h00000000;
			wdog_pend <= 1'b0;
		end
		else if (soft_clr)
		begin
			wdog      <= `CSD_ZERO16;
			wdog_cnt  <= 32'h00000000;
			wdog_pend <= 1'b0;
		end
		else if (wr_wdog)
		begin
			wdog      <= reg_wdata_i;
			wdog_cnt  <= WDOG_CYC - 32'h00000001;
			wdog_pend <= 1'b1;
		end
		else if (wdog_pend && wdog_cnt == 32'h00000000)
		begin
			wdog      <= ~wdog; // [R14]
			wdog_pend <= 1'b0;
		end
		else if (wdog_pend)
			wdog_cnt <= wdog_cnt - 32'h00000001;
	end

	// soft reset: level hold, then a timed reboot ending in a full clear
	reg        fw_hold;
	reg        booting;
	reg [31:0] boot_cnt;
	always @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fw_hold  <= 1'b0;
			booting  <= 1'b0;
			boot_cnt <= 32'h00000000;
			soft_clr <= 1'b0;
		end
		else
		begin
			soft_clr <= 1'b0;
			if (wr_soft && reg_wdata_i[`CSD_SOFT_RST_BIT])
			begin
				fw_hold  <= 1'b1; // [R12]
				booting  <= 1'b0;
			end
			else if (wr_soft && fw_hold)
			begin
				fw_hold  <= 1'b0;
				booting  <= 1'b1;
				boot_cnt <= BOOT_CYC - 32'h00000001; // [R12]
			end
			else if (booting && boot_cnt == 32'h00000000)
			begin
				booting  <= 1'b0;
				soft_clr <= 1'b1; // [R13]
			end
			else if (booting)
				boot_cnt <= boot_cnt - 32'h00000001;
		end
	end
	assign firmware_reset_o = fw_hold | booting;

	// read mux; unmapped offsets in the window read zero
	reg [`CSD_DW-1:0] next_rdata;
	always @*
	begin
		next_rdata = `CSD_ZERO16;
		case (reg_addr_i) // [R21]
			`CSD_ADDR_ACTIVE:    next_rdata = {8'h00, active};
			`CSD_ADDR_TEST_EN:   next_rdata = test_en;
			`CSD_ADDR_SIG_STAT:  next_rdata = {8'h00, stat_all[`CSD_SRC_SIG*`CSD_NCH +: `CSD_NCH]}; // [R07]
			`CSD_ADDR_REF_STAT:  next_rdata = {8'h00, stat_all[`CSD_SRC_REF*`CSD_NCH +: `CSD_NCH]}; // [R04]
			`CSD_ADDR_TEST_STAT: next_rdata = {8'h00, stat_all[`CSD_SRC_TEST*`CSD_NCH +: `CSD_NCH]}; // [R01]
			`CSD_ADDR_IRQ_EN:    next_rdata = {13'h0000, irq_en};
			`CSD_ADDR_IRQ_STAT:  next_rdata = {13'h0000, irq_stat}; // [R17]
			`CSD_ADDR_WDOG:      next_rdata = wdog;
			`CSD_ADDR_PART:      next_rdata = PART_ID; // [R18]
			`CSD_ADDR_SERIAL:    next_rdata = SERIAL_NO; // [R18]
			`CSD_ADDR_DATE:      next_rdata = DATE_CODE; // [R19]
			`CSD_ADDR_REV_IFACE: next_rdata = REV_IFACE; // [R20]
			`CSD_ADDR_REV_LOGIC: next_rdata = REV_LOGIC; // [R20]
			default:             next_rdata = `CSD_ZERO16;
		endcase
	end

	// registered read answer, one cycle after the strobe
	always @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reg_rdata_o  <= `CSD_ZERO16;
			reg_rvalid_o <= 1'b0;
		end
		else
		begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i)
				reg_rdata_o <= next_rdata;
		end
	end

	// controls out to the converter core
	assign active_channels_o          = active;
	assign internal_stimulus_test_o   = test_en[`CSD_TEST_STIMULUS];
	assign user_angle_loopback_test_o = test_en[`CSD_TEST_LOOPBACK];
	assign background_accuracy_test_o = test_en[`CSD_TEST_BACKGROUND];

endmodule

// ### bench/csd_status_regs_properties.sv
// port assertions for the status and diagnostic register bank
// assumes the bench's scaled boot count of 10 cycles
`timescale 1ns/1ns
module csd_status_props (
	// clock and reset
	input wire        clk_i,
	input wire        resetn_i,
	// register window
	input wire [9:0]  reg_addr_i,
	input wire        reg_wr_i,
	input wire        reg_rd_i,
	input wire [15:0] reg_wdata_i,
	input wire [15:0] reg_rdata_o,
	input wire        reg_rvalid_o,
	// controls and request
	input wire [7:0]  active_channels_o,
	input wire        internal_stimulus_test_o,
	input wire        firmware_reset_o,
	input wire        irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	// soft reset steps: hold, then release while held
	sequence s_hold;
		reg_wr_i && reg_addr_i == 10'h10C && reg_wdata_i[0];
	endsequence
	sequence s_release;
		firmware_reset_o && reg_wr_i && reg_addr_i == 10'h10C && !reg_wdata_i[0];
	endsequence

	property p_rvalid; reg_rd_i |=> reg_rvalid_o; endproperty
	property p_no_rvalid; !reg_rd_i |=> !reg_rvalid_o; endproperty
	property p_unmapped; reg_rd_i && reg_addr_i == 10'h3FC |=> reg_rdata_o == 16'h0000; endproperty
	property p_hold_rdata; !reg_rd_i && !firmware_reset_o |=> $stable(reg_rdata_o); endproperty
	property p_fw_hold; s_hold |=> firmware_reset_o; endproperty
	property p_boot; s_release |=> firmware_reset_o [*8]; endproperty
	property p_boot_end; s_release |-> ##[9:12] $fell(firmware_reset_o); endproperty
	property p_clear; $fell(firmware_reset_o) |=> active_channels_o == 8'h00 && !irq_o; endproperty
	property p_stim;
		reg_wr_i && reg_addr_i == 10'h07C |=> internal_stimulus_test_o == $past(reg_wdata_i[3]);
	endproperty
	property p_active;
		reg_wr_i && reg_addr_i == 10'h074 |=> active_channels_o == $past(reg_wdata_i[7:0]);
	endproperty

	a_rvalid: assert property (p_rvalid) else $error("no read answer");
	a_no_rvalid: assert property (p_no_rvalid) else $error("stray read answer");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_hold_rdata: assert property (p_hold_rdata) else $error("read data moved");
	a_fw_hold: assert property (p_fw_hold) else $error("firmware reset not held");
	a_boot: assert property (p_boot) else $error("reboot ended early");
	a_boot_end: assert property (p_boot_end) else $error("reboot too long");
	a_clear: assert property (p_clear) else $error("registers not cleared");
	a_stim: assert property (p_stim) else $error("stimulus enable wrong");
	a_active: assert property (p_active) else $error("active mask wrong");
endmodule

bind csd_status_regs csd_status_props csd_status_props_i (
	.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
	.reg_rvalid_o(reg_rvalid_o), .active_channels_o(active_channels_o),
	.internal_stimulus_test_o(internal_stimulus_test_o),
	.firmware_reset_o(firmware_reset_o), .irq_o(irq_o)
);

// ### bench/csd_host_model.sv
// host driver model: register accesses on the window port
// assumes strobes sampled on rising edges; drives on falling edges
`timescale 1ns/1ns
module csd_host_model #(
	parameter SCAN_CYC = 20,
	parameter WDOG_CYC = 10000
) (
	// clock and read answer
	input  wire        clk_i,
	input  wire [15:0] rdata_i,
	input  wire        rvalid_i,
	// request
	output reg  [9:0]  addr_o,
	output reg         wr_o,
	output reg         rd_o,
	output reg  [15:0] wdata_o
);
	// idle bus
	initial
	begin
		addr_o = 10'h3FF;
		wr_o = 1'b0;
		rd_o = 1'b0;
		wdata_o = 16'h0000;
	end

	// released lines show the inverse so stale values never match
	task wr(input [9:0] a, input [15:0] d);
		@(negedge clk_i);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge clk_i);
		wr_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask

	// a missing answer returns the inverse, so it cannot pass
	task rd(input [9:0] a, output [15:0] d);
		@(negedge clk_i);
		addr_o = a;
		rd_o = 1'b1;
		@(negedge clk_i);
		rd_o = 1'b0;
		addr_o = ~a;
		d = rvalid_i ? rdata_i : ~rdata_i;
	endtask

	// only used channels marked active, avoids false faults
	task set_active(input [7:0] m);
		wr(10'h074, {8'h00, m});
	endtask

	// allow a full scan before trusting status
	task settle;
		repeat (SCAN_CYC + 2) @(negedge clk_i);
	endtask

	// allow the inversion time before checking the watchdog
	task wdog_wait;
		repeat (WDOG_CYC + 2) @(negedge clk_i);
	endtask
endmodule

// ### bench/csd_status_regs_tb.sv
// self-checking bench for the status and diagnostic register bank
// assumes scaled counts: scan 20, loss 10, boot 10, test 30; watchdog at full length
`timescale 1ns/1ns
module csd_status_regs_tb;
	typedef struct { logic [9:0] a; logic w; logic [15:0] d; logic [15:0] e; } csd_row_t;
	logic        clk_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic [7:0]  sig_ok_i = 8'hFF;
	logic [7:0]  ref_ok_i = 8'hFF;
	logic [7:0]  test_fail_i = 8'h00;
	wire  [9:0]  reg_addr_i;
	wire         reg_wr_i;
	wire         reg_rd_i;
	wire  [15:0] reg_wdata_i;
	wire  [15:0] reg_rdata_o;
	wire         reg_rvalid_o;
	wire  [7:0]  active_channels_o;
	wire         internal_stimulus_test_o;
	wire         user_angle_loopback_test_o;
	wire         background_accuracy_test_o;
	wire         firmware_reset_o;
	wire         irq_o;
	logic [15:0] v;
	int          mismatches = 0;
	int          checked = 0;
	// reset value, ids, read-only and unmapped places, enable width
	csd_row_t    rows [9] = '{
		'{10'h098, 1'b0, 16'h0000, 16'h0000}, '{10'h110, 1'b0, 16'h0000, 16'h1234},
		'{10'h110, 1'b1, 16'hFFFF, 16'h1234}, '{10'h114, 1'b0, 16'h0000, 16'h0001},
		'{10'h118, 1'b0, 16'h0000, 16'h2401}, '{10'h124, 1'b0, 16'h0000, 16'h0001},
		'{10'h128, 1'b0, 16'h0000, 16'h0001}, '{10'h3FC, 1'b1, 16'hBEEF, 16'h0000},
		'{10'h098, 1'b1, 16'hFFFF, 16'h0007}};

	always #5 clk_i = ~clk_i;

	csd_host_model csd_host_model_i (.clk_i(clk_i), .rdata_i(reg_rdata_o),
		.rvalid_i(reg_rvalid_o), .addr_o(reg_addr_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i), .wdata_o(reg_wdata_i));

	csd_status_regs #(.SCAN_CYC(32'd20), .LOSS_CYC(32'd10), .BOOT_CYC(32'd10),
		.TEST_CYC(36'd30)) csd_status_regs_i (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.reg_rvalid_o(reg_rvalid_o), .sig_ok_i(sig_ok_i), .ref_ok_i(ref_ok_i), .test_fail_i(test_fail_i),
		.active_channels_o(active_channels_o), .internal_stimulus_test_o(internal_stimulus_test_o),
		.user_angle_loopback_test_o(user_angle_loopback_test_o),
		.background_accuracy_test_o(background_accuracy_test_o), .firmware_reset_o(firmware_reset_o),
		.irq_o(irq_o));

	task chk(input string n, input [15:0] e, input [15:0] g);
		checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task rc(input [9:0] a, input [15:0] e);
		csd_host_model_i.rd(a, v);
		chk($sformatf("reg %h", a), e, v);
	endtask

	// monitor dip longer than the loss filter, then restored
	task drop(input [7:0] s, input [7:0] r);
		@(negedge clk_i);
		sig_ok_i = ~s;
		ref_ok_i = ~r;
		repeat (12) @(negedge clk_i);
		sig_ok_i = 8'hFF;
		ref_ok_i = 8'hFF;
	endtask

	task summarize;
		$display("comparisons %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// hang guard, well beyond the roughly 10,500 cycles of tests
	initial
	begin
		#150000;
		mismatches++;
		summarize;
	end

	// main sequence
	initial
	begin
		repeat (10) @(negedge clk_i);
		resetn_i = 1'b1;
		repeat (3) @(negedge clk_i);
		foreach (rows[i])
		begin
			if (rows[i].w)
				csd_host_model_i.wr(rows[i].a, rows[i].d);
			rc(rows[i].a, rows[i].e);
		end
		$display("test table done");
		csd_host_model_i.set_active(8'h0F);
		csd_host_model_i.settle;
		rc(10'h080, 16'h000F);
		rc(10'h084, 16'h000F);
		rc(10'h088, 16'h000F);
		drop(8'h00, 8'h01);
		csd_host_model_i.settle;
		chk("irq", 16'h0001, {15'h0000, irq_o});
		rc(10'h084, 16'h000E);
		rc(10'h09C, 16'h0002);
		rc(10'h09C, 16'h0000);
		chk("irq", 16'h0000, {15'h0000, irq_o});
		csd_host_model_i.settle;
		rc(10'h084, 16'h000F);
		$display("test reference loss done");
		csd_host_model_i.wr(10'h07C, 16'h0008);
		chk("stimulus", 16'h0001, {15'h0000, internal_stimulus_test_o});
		drop(8'h02, 8'h02);
		csd_host_model_i.settle;
		rc(10'h080, 16'h000F);
		rc(10'h084, 16'h000F);
		csd_host_model_i.wr(10'h07C, 16'h0005);
		chk("loop bg", 16'h0003, {14'h0000, user_angle_loopback_test_o, background_accuracy_test_o});
		$display("test suspend done");
		// one-cycle failure, caught although transient
		@(negedge clk_i);
		test_fail_i = 8'h04;
		@(negedge clk_i);
		test_fail_i = 8'h00;
		repeat (100) @(negedge clk_i);
		rc(10'h088, 16'h000B);
		rc(10'h09C, 16'h0004);
		csd_host_model_i.wr(10'h07C, 16'h0000);
		drop(8'h02, 8'h00);
		csd_host_model_i.settle;
		rc(10'h080, 16'h000D);
		rc(10'h09C, 16'h0001);
		// signal source masked: loss latches status but raises nothing
		csd_host_model_i.wr(10'h098, 16'h0006);
		drop(8'h04, 8'h00);
		csd_host_model_i.settle;
		chk("irq masked", 16'h0000, {15'h0000, irq_o});
		rc(10'h09C, 16'h0000);
		rc(10'h080, 16'h000B);
		$display("test failures done");
		csd_host_model_i.wr(10'h108, 16'hA5C3);
		rc(10'h108, 16'hA5C3);
		csd_host_model_i.wdog_wait;
		rc(10'h108, 16'h5A3C);
		rc(10'h108, 16'h5A3C);
		$display("test watchdog done");
		csd_host_model_i.wr(10'h10C, 16'h0001);
		repeat (20) @(negedge clk_i);
		chk("fw reset", 16'h0001, {15'h0000, firmware_reset_o});
		csd_host_model_i.wr(10'h10C, 16'h0000);
		repeat (14) @(negedge clk_i);
		chk("fw reset", 16'h0000, {15'h0000, firmware_reset_o});
		rc(10'h108, 16'h0000);
		rc(10'h074, 16'h0000);
		rc(10'h098, 16'h0000);
		$display("test soft reset done");
		summarize;
	end
endmodule
